// File: verilog/ttl_cfg.svh
`ifndef TTL_CFG_SVH
`define TTL_CFG_SVH

// Register addresses
`define TTL_ADDR_INT_STATUS2 8'h42
`define TTL_ADDR_INT_MASK2 8'h75
`define TTL_ADDR_DURATION 8'h79
`define TTL_ADDR_LIMIT 8'h7a
`define TTL_ADDR_PULSES 8'h7b

// Field positions
`define TTL_FOURTH_BIT 5
`define TTL_FIRST_FAN_PULSE_SELECT_LSB 0
`define TTL_SECOND_FAN_PULSE_SELECT_LSB 2
`define TTL_THIRD_FAN_PULSE_SELECT_LSB 4
`define TTL_FOURTH_FAN_PULSE_SELECT_LSB 6

// Reset values
`define TTL_LIMIT_RESET 8'h00
`define TTL_PULSES_RESET 8'h55

// Timing
`define TTL_CLK_MHZ 100
`define TTL_STEP_TIME_MS 22.76
`define TTL_REPORT_TIME_MS 45.52
`define TTL_STEP_CYCLES (int'(`TTL_STEP_TIME_MS * 1.0e3 * `TTL_CLK_MHZ))
`define TTL_REPORT_MIN_STEPS (int'(`TTL_REPORT_TIME_MS / `TTL_STEP_TIME_MS))

`endif

// File: verilog/ttl_pkg.sv
`default_nettype none
package ttl_pkg;
   typedef enum logic [0:0] {
      TTL_IDLE = 1'h0,
      TTL_ASSERTED = 1'h1
   } ttl_state_t;

   typedef logic [7:0] ttl_byte_t;
endpackage
`default_nettype wire

// File: verilog/ttl_step_div.sv
`timescale 1ns/1ns
`default_nettype none
`include "ttl_cfg.svh"

module ttl_step_div #(
   parameter int unsigned STEP_CYCLES = `TTL_STEP_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   output logic tick
);
   localparam int unsigned W = $clog2(STEP_CYCLES);

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic tick_reg;
   logic tick_next;

   if (STEP_CYCLES < 2) begin : g_chk
      $error("STEP_CYCLES must be at least 2");
   end

   // Restarts on every new assertion so steps align to its start
   always_comb begin
      cnt_next = cnt_reg;
      tick_next = 1'b0;
      if (!run) begin
         cnt_next = '0;
      end else if (cnt_reg == W'(STEP_CYCLES - 1)) begin
         cnt_next = '0;
         tick_next = 1'b1;
      end else begin
         cnt_next = cnt_reg + W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;

   property tick_single_p;
      @(posedge clk) disable iff (rst) tick |=> !tick;
   endproperty
   tick_single_a: assert property (tick_single_p)
      else $error("step tick lasted more than one cycle");
endmodule

`default_nettype wire

// File: verilog/ttl_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "ttl_cfg.svh"

// Notes on behaviour
// - The limit register is an 8-bit value that software reads and writes.
// - One limit step equals 22.76 ms, so limits span 45.52 ms to 5.80 s.
// - When the measured assertion time passes the limit, bit 5 of status register 0x42 is set.
// - A limit of zero sets the flag at once when the thermal input becomes asserted.
// - Pulse-count bits 1:0 pick 1 to 4 pulses per measurement for the first fan.
// - Pulse-count bits 3:2 pick 1 to 4 pulses per measurement for the second fan.
// - Pulse-count bits 5:4 pick 1 to 4 pulses per measurement for the third fan.
// - Pulse-count bits 7:6 pick 1 to 4 pulses per measurement for the fourth fan.
// - The pulse-count register resets to 0x55, two pulses for every fan.
// - The limit register resets to zero.
// - A read-only timer measures assertion time, its bits 7:1 reading zero below 45.52 ms.
// - With the fourth tach pin used as thermal input, mask bit 5 of 0x75 silences the alert.
module ttl_regs #(
   parameter int unsigned STEP_CYCLES = `TTL_STEP_CYCLES
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   input wire logic THERMAL_EVENT_PIN_N,
   input wire logic FOURTH_TACH_IS_THERMAL,
   output logic [7:0] ASSERT_TIME_LIMIT_VALUE,
   output logic [7:0] ASSERT_DURATION_COUNT,
   output logic [1:0] FIRST_FAN_PULSE_SELECT,
   output logic [1:0] SECOND_FAN_PULSE_SELECT,
   output logic [1:0] THIRD_FAN_PULSE_SELECT,
   output logic [1:0] FOURTH_FAN_PULSE_SELECT,
   output logic [2:0] FIRST_FAN_PULSES,
   output logic [2:0] SECOND_FAN_PULSES,
   output logic [2:0] THIRD_FAN_PULSES,
   output logic [2:0] FOURTH_FAN_PULSES,
   output logic FOURTH_TACH_OR_TIMER_FLAG,
   output logic TIMER_LIMIT_ALERT
);
   localparam logic [7:0] MIN_STEPS = 8'(`TTL_REPORT_MIN_STEPS);

   // Reported reading: steps only once the shortest reportable time is reached
   function automatic logic [7:0] ttl_reading(input logic [7:0] steps, input logic asrt);
      if (steps >= MIN_STEPS) begin
         return steps;
      end
      return {7'h00, asrt};
   endfunction

   // Pulses counted for a two-bit select: 00 -> 1 ... 11 -> 4
   function automatic logic [2:0] ttl_pulses(input logic [1:0] sel);
      return {1'b0, sel} + 3'h1;
   endfunction

   logic sync1_reg;
   logic sync2_reg;
   ttl_pkg::ttl_state_t state_reg;
   ttl_pkg::ttl_state_t state_next;
   ttl_pkg::ttl_byte_t limit_reg;
   ttl_pkg::ttl_byte_t limit_next;
   ttl_pkg::ttl_byte_t pulses_reg;
   ttl_pkg::ttl_byte_t pulses_next;
   ttl_pkg::ttl_byte_t steps_reg;
   ttl_pkg::ttl_byte_t steps_next;
   logic asrt_reg;
   logic asrt_next;
   logic flag_reg;
   logic flag_next;
   logic mask_reg;
   logic mask_next;
   logic alert_reg;
   logic alert_next;
   ttl_pkg::ttl_byte_t rdata_reg;
   ttl_pkg::ttl_byte_t rdata_next;
   logic rvalid_reg;
   logic rvalid_next;

   logic asserted;
   logic starting;
   logic tick;
   logic rd_duration;
   logic rd_status;
   logic flag_set;
   ttl_pkg::ttl_byte_t reading_next;

   // Pin crosses in through two flops; only sync2 is looked at
   always_ff @(posedge CLK) begin
      if (RST) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end else begin
         sync1_reg <= THERMAL_EVENT_PIN_N;
         sync2_reg <= sync1_reg;
      end
   end

   assign asserted = ~sync2_reg;
   assign starting = asserted && (state_reg == ttl_pkg::TTL_IDLE);
   assign rd_duration = REG_RD && (REG_ADDR == `TTL_ADDR_DURATION);
   assign rd_status = REG_RD && (REG_ADDR == `TTL_ADDR_INT_STATUS2);

   ttl_step_div #(
      .STEP_CYCLES(STEP_CYCLES)
   ) u_step_div (
      .clk(CLK),
      .rst(RST),
      .run(state_reg == ttl_pkg::TTL_ASSERTED),
      .tick(tick)
   );

   // Assertion tracking
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ttl_pkg::TTL_IDLE: begin
            if (asserted) begin
               state_next = ttl_pkg::TTL_ASSERTED;
            end
         end
         ttl_pkg::TTL_ASSERTED: begin
            if (!asserted) begin
               state_next = ttl_pkg::TTL_IDLE;
            end
         end
         default: begin
            state_next = ttl_pkg::TTL_IDLE;
         end
      endcase
   end

   // Duration timer, limit flag and alert
   always_comb begin
      steps_next = steps_reg;
      asrt_next = asrt_reg;
      if (rd_duration) begin
         steps_next = 8'h00;
         asrt_next = 1'b0;
      end
      if (tick && (state_reg == ttl_pkg::TTL_ASSERTED) && (steps_reg != 8'hff)) begin
         steps_next = steps_next + 8'h01;
      end
      if (asserted) begin
         asrt_next = 1'b1;
      end
      reading_next = ttl_reading(steps_next, asrt_next);
      flag_set = 1'b0;
      if (starting && (limit_reg == 8'h00)) begin
         flag_set = 1'b1;
      end
      if (tick && (state_reg == ttl_pkg::TTL_ASSERTED) && (limit_reg != 8'h00) && (reading_next > limit_reg)) begin
         flag_set = 1'b1;
      end
      flag_next = flag_reg;
      if (rd_status) begin
         flag_next = 1'b0;
      end
      if (flag_set) begin
         flag_next = 1'b1;
      end
      alert_next = flag_next && !(FOURTH_TACH_IS_THERMAL && mask_next);
   end

   // Register writes and reads
   always_comb begin
      limit_next = limit_reg;
      pulses_next = pulses_reg;
      mask_next = mask_reg;
      if (REG_WR) begin
         case (REG_ADDR)
            `TTL_ADDR_LIMIT: begin
               limit_next = REG_WDATA;
            end
            `TTL_ADDR_PULSES: begin
               pulses_next = REG_WDATA;
            end
            `TTL_ADDR_INT_MASK2: begin
               mask_next = REG_WDATA[`TTL_FOURTH_BIT];
            end
            default: begin
               limit_next = limit_reg;
            end
         endcase
      end
      rvalid_next = REG_RD;
      rdata_next = rdata_reg;
      if (REG_RD) begin
         rdata_next = 8'h00;
         case (REG_ADDR)
            `TTL_ADDR_LIMIT: begin
               rdata_next = limit_reg;
            end
            `TTL_ADDR_PULSES: begin
               rdata_next = pulses_reg;
            end
            `TTL_ADDR_DURATION: begin
               rdata_next = ttl_reading(steps_reg, asrt_reg);
            end
            `TTL_ADDR_INT_STATUS2: begin
               rdata_next[`TTL_FOURTH_BIT] = flag_reg;
            end
            `TTL_ADDR_INT_MASK2: begin
               rdata_next[`TTL_FOURTH_BIT] = mask_reg;
            end
            default: begin
               rdata_next = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state_reg <= ttl_pkg::TTL_IDLE;
         limit_reg <= `TTL_LIMIT_RESET;
         pulses_reg <= `TTL_PULSES_RESET;
         steps_reg <= 8'h00;
         asrt_reg <= 1'b0;
         flag_reg <= 1'b0;
         mask_reg <= 1'b0;
         alert_reg <= 1'b0;
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         limit_reg <= limit_next;
         pulses_reg <= pulses_next;
         steps_reg <= steps_next;
         asrt_reg <= asrt_next;
         flag_reg <= flag_next;
         mask_reg <= mask_next;
         alert_reg <= alert_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign REG_RDATA = rdata_reg;
   assign REG_RVALID = rvalid_reg;
   assign ASSERT_TIME_LIMIT_VALUE = limit_reg;
   assign ASSERT_DURATION_COUNT = ttl_reading(steps_reg, asrt_reg);
   assign FIRST_FAN_PULSE_SELECT = pulses_reg[`TTL_FIRST_FAN_PULSE_SELECT_LSB +: 2];
   assign SECOND_FAN_PULSE_SELECT = pulses_reg[`TTL_SECOND_FAN_PULSE_SELECT_LSB +: 2];
   assign THIRD_FAN_PULSE_SELECT = pulses_reg[`TTL_THIRD_FAN_PULSE_SELECT_LSB +: 2];
   assign FOURTH_FAN_PULSE_SELECT = pulses_reg[`TTL_FOURTH_FAN_PULSE_SELECT_LSB +: 2];
   assign FIRST_FAN_PULSES = ttl_pulses(FIRST_FAN_PULSE_SELECT);
   assign SECOND_FAN_PULSES = ttl_pulses(SECOND_FAN_PULSE_SELECT);
   assign THIRD_FAN_PULSES = ttl_pulses(THIRD_FAN_PULSE_SELECT);
   assign FOURTH_FAN_PULSES = ttl_pulses(FOURTH_FAN_PULSE_SELECT);
   assign FOURTH_TACH_OR_TIMER_FLAG = flag_reg;
   assign TIMER_LIMIT_ALERT = alert_reg;

   limit_reset_a: assert property (
      @(posedge CLK) RST |=> (ASSERT_TIME_LIMIT_VALUE == 8'h00))
      else $error("limit not cleared by reset");

   pulses_reset_a: assert property (
      @(posedge CLK) RST |=> (FIRST_FAN_PULSES == 3'h2) && (FOURTH_FAN_PULSES == 3'h2)
         && (SECOND_FAN_PULSE_SELECT == 2'h1) && (THIRD_FAN_PULSE_SELECT == 2'h1))
      else $error("pulse select not preset to two pulses");

   limit_write_a: assert property (
      @(posedge CLK) disable iff (RST)
      (REG_WR && REG_ADDR == `TTL_ADDR_LIMIT)
         |=> (ASSERT_TIME_LIMIT_VALUE == $past(REG_WDATA)))
      else $error("limit differs from written value");

   pulse_fields_a: assert property (
      @(posedge CLK) disable iff (RST)
      (REG_WR && REG_ADDR == `TTL_ADDR_PULSES && REG_WDATA == 8'he4)
         |=> (FIRST_FAN_PULSES == 3'h1) && (SECOND_FAN_PULSES == 3'h2)
         && (THIRD_FAN_PULSES == 3'h3) && (FOURTH_FAN_PULSES == 3'h4))
      else $error("fan pulse fields decoded wrongly");

   zero_limit_a: assert property (
      @(posedge CLK) disable iff (RST)
      (starting && ASSERT_TIME_LIMIT_VALUE == 8'h00) |=> FOURTH_TACH_OR_TIMER_FLAG)
      else $error("zero limit did not flag at assertion");

   exceed_flag_a: assert property (
      @(posedge CLK) disable iff (RST)
      (tick && state_reg == ttl_pkg::TTL_ASSERTED && limit_reg != 8'h00 && reading_next > limit_reg)
         |=> FOURTH_TACH_OR_TIMER_FLAG)
      else $error("flag missing in step that exceeded limit");

   flag_cause_a: assert property (
      @(posedge CLK) disable iff (RST)
      $rose(FOURTH_TACH_OR_TIMER_FLAG) |-> ($past(starting) && ($past(limit_reg) == 8'h00))
         || ($past(tick) && ($past(limit_reg) != 8'h00) && ($past(reading_next) > $past(limit_reg))))
      else $error("flag rose without exceeding limit");

   short_time_a: assert property (
      @(posedge CLK) disable iff (RST)
      (steps_reg < MIN_STEPS) |-> (ASSERT_DURATION_COUNT[7:1] == 7'h00))
      else $error("timer upper bits nonzero below shortest time");

   alert_mask_a: assert property (
      @(posedge CLK) disable iff (RST)
      TIMER_LIMIT_ALERT |-> $past(flag_next) && !($past(FOURTH_TACH_IS_THERMAL) && $past(mask_next)))
      else $error("alert not gated by fourth tach mask");
endmodule

`default_nettype wire

// File: verif/ttl_thermal_event_pin_src.sv
`timescale 1ns/1ns
`default_nettype none
// Thermal source: pulls the active-low pin for a commanded span
module ttl_thermal_event_pin_src (
   input wire logic clk,
   input wire logic fire,
   input wire logic [7:0] hold,
   output logic pin_n
);
   initial begin
      pin_n = 1'b1;
      forever begin
         @(posedge clk);
         if (fire) begin
            pin_n <= 1'b0;
            repeat (hold) @(posedge clk);
            // Released pin returns to its pull-up level
            pin_n <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd_s = 1'b0, fire = 1'b0, fourth = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, hold = 8'h00, v;
   logic pin_n, flag, alert, rvalid;
   logic [7:0] rdata, lim, dur;
   logic [7:0] exp_v;
   logic [1:0] s1, s2, s3, s4;
   logic [2:0] p1, p2, p3, p4;
   logic [7:0] exp_q[$];
   int err_total = 0, checks_done = 0;
   always #5 clk = ~clk;
   ttl_thermal_event_pin_src ttl_thermal_event_pin_src_i (.clk(clk), .fire(fire), .hold(hold), .pin_n(pin_n));
   ttl_regs #(.STEP_CYCLES(8)) ttl_regs_i (.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr),
      .REG_WDATA(wdata), .REG_RD(rd_s), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .THERMAL_EVENT_PIN_N(pin_n), .FOURTH_TACH_IS_THERMAL(fourth), .ASSERT_TIME_LIMIT_VALUE(lim),
      .ASSERT_DURATION_COUNT(dur), .FIRST_FAN_PULSE_SELECT(s1), .SECOND_FAN_PULSE_SELECT(s2),
      .THIRD_FAN_PULSE_SELECT(s3), .FOURTH_FAN_PULSE_SELECT(s4), .FIRST_FAN_PULSES(p1),
      .SECOND_FAN_PULSES(p2), .THIRD_FAN_PULSES(p3), .FOURTH_FAN_PULSES(p4),
      .FOURTH_TACH_OR_TIMER_FLAG(flag), .TIMER_LIMIT_ALERT(alert));
   task automatic finish_test;
      $display("checks_done=%0d err_total=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      rd_s <= 1'b0;
   endtask
   task automatic thermal_event_pin(input logic [7:0] n);
      @(posedge clk);
      fire <= 1'b1;
      hold <= n;
      @(posedge clk);
      fire <= 1'b0;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   // Read result monitor
   always @(posedge clk) begin
      if (rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, rdata, 8'h00);
         end else begin
            exp_v = exp_q.pop_front();
            `CHK(rdata, exp_v)
         end
      end
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      finish_test();
   end
   initial begin
      void'($urandom(66));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      wait_cyc(1);
      `CHK({p1, p2, p3, p4}, {4{3'h2}})
      rd_reg(8'h7a, 8'h00);
      rd_reg(8'h7b, 8'h55);
      rd_reg(8'h79, 8'h00);
      rd_reg(8'h42, 8'h00);
      rd_reg(8'h10, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr_reg(8'h7b, {4{c[1:0]}});
         wait_cyc(1);
         `CHK({s4, s3, s2, s1}, {4{c[1:0]}})
         `CHK({p1, p2, p3, p4}, {4{c[2:0] + 3'h1}})
      end
      wr_reg(8'h7b, 8'he4);
      wait_cyc(1);
      `CHK({p4, p3, p2, p1}, {3'h4, 3'h3, 3'h2, 3'h1})
      v = 8'($urandom());
      wr_reg(8'h7b, v);
      rd_reg(8'h7b, v);
      v = 8'($urandom());
      wr_reg(8'h7a, v);
      rd_reg(8'h7a, v);
      `CHK(lim, v)
      wr_reg(8'h42, 8'hff);
      wr_reg(8'h79, 8'hff);
      wr_reg(8'h10, 8'hff);
      rd_reg(8'h10, 8'h00);
      rd_reg(8'h42, 8'h00);
      rd_reg(8'h79, 8'h00);
      // Zero limit fires at assertion
      wr_reg(8'h7a, 8'h00);
      thermal_event_pin(8'h04);
      wait_cyc(6);
      `CHK({flag, alert}, 2'b11)
      wait_cyc(6);
      rd_reg(8'h42, 8'h20);
      rd_reg(8'h42, 8'h00);
      rd_reg(8'h79, 8'h01);
      // Masked alert with fourth tach as thermal input
      wr_reg(8'h75, 8'h20);
      fourth <= 1'b1;
      thermal_event_pin(8'h04);
      wait_cyc(8);
      `CHK({flag, alert}, 2'b10)
      rd_reg(8'h75, 8'h20);
      fourth <= 1'b0;
      wait_cyc(2);
      `CHK(alert, 1'b1)
      rd_reg(8'h42, 8'h20);
      rd_reg(8'h79, 8'h01);
      // Limit 3: flag only once the fourth step passes it
      wr_reg(8'h7a, 8'h03);
      thermal_event_pin(8'd38);
      wait_cyc(32);
      `CHK(flag, 1'b0)
      wait_cyc(8);
      `CHK(flag, 1'b1)
      `CHK(dur, 8'h04)
      wait_cyc(10);
      rd_reg(8'h79, 8'h04);
      rd_reg(8'h42, 8'h20);
      wait_cyc(4);
      `CHK(exp_q.size(), 0)
      finish_test();
   end
endmodule
`default_nettype wire
